// >>> common/sss_defs.svh
// constants for the supply supervisor low-power state selector
//
// Behaviour
// (RL1) manual low side: core supervisor off in deep modes unless low-power enable set
// (RL2) automatic low side: core supervisor normal in deep modes only if enabled, lpm, full perf
// (RL3) manual low side: core monitor off if disabled, else keeps active state
// (RL4) automatic low side: core monitor normal in deep modes only when full perf
// (RL5) fast wakeup if low-side unit disabled or full perf, slow if normal
// (RL6) normal-performance low side holds cpu 150 us after deep wakeup
// (RL7) both low units disabled or full perf: hold-off only 2 us
// (RL8) comparator settle delay about 2 us full perf, 150 us normal
// (RL9) software waits for both settle flags clear before deep sleep
// (RL10) high supervisor state from enable, full perf, lpm enable, auto control
// (RL11) high monitor state from enable, full perf and auto control
// (RL12) subsystem clock not held off on wakeup, may run fast up to 6 us
// (RL13) software divides main clock by two before deep sleep, waits after wake
// (RL14) software selects normal low-side performance before raising core level
// (RL15) soft reset clears stuck no-wakeup condition
// (RL16) deep states applied on entry, active states restored before hold-off ends
`ifndef SSS_DEFS_SVH
`define SSS_DEFS_SVH
`define SSS_CLK_MHZ 100
`define SSS_SLOW_US 150
`define SSS_FAST_US 2
`define SSS_SLOW_CYC (`SSS_SLOW_US * `SSS_CLK_MHZ)
`define SSS_FAST_CYC (`SSS_FAST_US * `SSS_CLK_MHZ)
`define SSS_CNT_W 15
`endif

// >>> common/sss_pkg.sv
// types for the supply supervisor low-power state selector
package sss_pkg;
    typedef enum logic [1:0] {
        sss_off,
        sss_normal,
        sss_full
    } sss_unit_type;
    typedef enum logic [1:0] {
        sss_active,
        sss_deep,
        sss_hold
    } sss_phase_type;
endpackage : sss_pkg

// >>> rtl/sss_delay.sv
// one-shot down counter used for settle delays and wakeup hold-off
`include "sss_defs.svh"
module sss_delay (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [`SSS_CNT_W-1:0] load,
    output logic busy
);
    logic [`SSS_CNT_W-1:0] count;
    logic [`SSS_CNT_W-1:0] next_count;

    always_comb begin
        next_count = count;
        if (start) begin
            next_count = load;
        end else if (count != '0) begin
            next_count = count - `SSS_CNT_W'(1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign busy = (count != '0);
endmodule : sss_delay

// >>> rtl/sss_select.sv
// operating-state selection for low- and high-side supervisors and monitors
`include "sss_defs.svh"
module sss_select (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic core_sup_enable,
    input wire logic core_sup_lowpower_enable,
    input wire logic core_sup_full_perf,
    input wire logic core_mon_enable,
    input wire logic core_mon_full_perf,
    input wire logic low_side_auto_control,
    input wire logic high_sup_enable,
    input wire logic high_sup_lowpower_enable,
    input wire logic high_sup_full_perf,
    input wire logic high_mon_enable,
    input wire logic high_mon_full_perf,
    input wire logic high_side_auto_control,
    input wire logic low_ctl_write,
    input wire logic high_ctl_write,
    input wire logic deep_sleep_request,
    input wire logic wakeup_event,
    output sss_pkg::sss_unit_type core_supervisor,
    output sss_pkg::sss_unit_type core_monitor,
    output sss_pkg::sss_unit_type supply_supervisor_high,
    output sss_pkg::sss_unit_type supply_monitor_high,
    output logic low_side_settle_flag,
    output logic high_side_settle_flag,
    output logic slow_wakeup,
    output logic cpu_hold,
    output logic in_deep_sleep
);
    import sss_pkg::*;

    // -----------------------------------------------------------------
    // state decode
    // -----------------------------------------------------------------
    function automatic sss_unit_type act_state(input logic en, input logic fp);
        act_state = !en ? sss_off : (fp ? sss_full : sss_normal);
    endfunction : act_state

    // shared table: supervisors pass their low-power enable, monitors pass 1
    function automatic sss_unit_type deep_state(input logic en, input logic md,
                                                input logic fp, input logic auto_ctl);
        if (!en || !md) begin
            deep_state = sss_off;
        end else if (auto_ctl) begin
            deep_state = fp ? sss_normal : sss_off;
        end else begin
            deep_state = fp ? sss_full : sss_normal;
        end
    endfunction : deep_state

    sss_unit_type csup_act, csup_deep, cmon_act, cmon_deep;
    sss_unit_type hsup_act, hsup_deep, hmon_act, hmon_deep;
    assign csup_act = act_state(core_sup_enable, core_sup_full_perf);
    assign cmon_act = act_state(core_mon_enable, core_mon_full_perf);
    assign hsup_act = act_state(high_sup_enable, high_sup_full_perf); // [RL10]
    assign hmon_act = act_state(high_mon_enable, high_mon_full_perf); // [RL11]
    assign csup_deep = deep_state(core_sup_enable, core_sup_lowpower_enable,
                                  core_sup_full_perf, low_side_auto_control); // [RL1] [RL2]
    assign cmon_deep = deep_state(core_mon_enable, 1'b1, core_mon_full_perf,
                                  low_side_auto_control); // [RL3] [RL4]
    assign hsup_deep = deep_state(high_sup_enable, high_sup_lowpower_enable,
                                  high_sup_full_perf, high_side_auto_control); // [RL10]
    assign hmon_deep = deep_state(high_mon_enable, 1'b1, high_mon_full_perf,
                                  high_side_auto_control); // [RL11]

    // -----------------------------------------------------------------
    // wakeup speed
    // -----------------------------------------------------------------
    // any enabled low-side unit in normal performance forces the slow path
    logic slow_sel;
    assign slow_sel = (csup_act == sss_normal) || (cmon_act == sss_normal); // [RL5] [RL7]

    // -----------------------------------------------------------------
    // settle delays after control writes
    // -----------------------------------------------------------------
    logic [`SSS_CNT_W-1:0] low_settle_load;
    logic [`SSS_CNT_W-1:0] hold_load;
    assign low_settle_load = core_sup_full_perf ? `SSS_CNT_W'(`SSS_FAST_CYC)
                                                : `SSS_CNT_W'(`SSS_SLOW_CYC); // [RL8]
    assign hold_load = slow_sel ? `SSS_CNT_W'(`SSS_SLOW_CYC)
                                : `SSS_CNT_W'(`SSS_FAST_CYC); // [RL6] [RL7]

    sss_delay u_low_settle (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .start(low_ctl_write),
        .load(low_settle_load),
        .busy(low_side_settle_flag)
    );

    // high side uses the same settle rule on its own full-performance bit
    sss_delay u_high_settle (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .start(high_ctl_write),
        .load(high_sup_full_perf ? `SSS_CNT_W'(`SSS_FAST_CYC) : `SSS_CNT_W'(`SSS_SLOW_CYC)),
        .busy(high_side_settle_flag)
    );

    // -----------------------------------------------------------------
    // power phase sequencing
    // -----------------------------------------------------------------
    sss_phase_type phase, next_phase;
    logic hold_start;
    logic hold_busy;
    logic next_slow;
    logic settling;
    // entry while a settle delay runs is the no-wakeup hazard; it is refused
    assign settling = low_side_settle_flag || high_side_settle_flag; // [RL9]

    always_comb begin
        next_phase = phase;
        next_slow = slow_wakeup;
        hold_start = 1'b0;
        case (phase)
            sss_active: begin
                if (deep_sleep_request && !settling) begin
                    next_phase = sss_deep; // [RL16]
                    next_slow = slow_sel; // [RL5]
                end
            end
            sss_deep: begin
                if (wakeup_event) begin
                    next_phase = sss_hold;
                    hold_start = 1'b1; // [RL6]
                end
            end
            sss_hold: begin
                if (!hold_busy && !hold_start) begin
                    next_phase = sss_active;
                end
            end
            default: begin
                next_phase = sss_active;
            end
        endcase
    end

    // soft reset lands here too, so a stuck deep phase always recovers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            phase <= sss_active; // [RL15]
            slow_wakeup <= 1'b0;
        end else begin
            phase <= next_phase;
            slow_wakeup <= next_slow;
        end
    end

    sss_delay u_hold (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .start(hold_start),
        .load(hold_load),
        .busy(hold_busy)
    );

    // -----------------------------------------------------------------
    // unit state outputs
    // -----------------------------------------------------------------
    sss_unit_type next_csup, next_cmon, next_hsup, next_hmon;
    always_comb begin
        if (next_phase == sss_deep) begin
            next_csup = csup_deep; // [RL16]
            next_cmon = cmon_deep;
            next_hsup = hsup_deep;
            next_hmon = hmon_deep;
        end else begin
            // active states back from the first hold cycle
            next_csup = csup_act; // [RL16]
            next_cmon = cmon_act;
            next_hsup = hsup_act;
            next_hmon = hmon_act;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            core_supervisor <= sss_off;
            core_monitor <= sss_off;
            supply_supervisor_high <= sss_off;
            supply_monitor_high <= sss_off;
        end else begin
            core_supervisor <= next_csup;
            core_monitor <= next_cmon;
            supply_supervisor_high <= next_hsup;
            supply_monitor_high <= next_hmon;
        end
    end

    // subsystem clock is deliberately not gated by cpu_hold [RL12]
    assign cpu_hold = (phase == sss_hold); // [RL6]
    assign in_deep_sleep = (phase == sss_deep);
endmodule : sss_select

// >>> sim/sss_chk_pkg.sv
// expected supervisor and monitor states shared by the bench and the checker
package sss_chk_pkg;
    import sss_pkg::*;
    // deep state: e enable, m low-power enable, f full perf, a automatic control
    function automatic sss_unit_type dp(logic e, logic m, logic f, logic a);
        if (!(e && m)) return sss_off;
        if (a) return f ? sss_normal : sss_off;
        return f ? sss_full : sss_normal;
    endfunction : dp
    function automatic sss_unit_type ac(logic e, logic f);
        return e ? (f ? sss_full : sss_normal) : sss_off;
    endfunction : ac
endpackage : sss_chk_pkg

// >>> sim/sss_select_asserts.sv
// concurrent checks on the supervisor state selector ports
module sss_select_asserts
    import sss_pkg::*, sss_chk_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic core_sup_enable,
    input wire logic core_sup_lowpower_enable,
    input wire logic core_sup_full_perf,
    input wire logic core_mon_enable,
    input wire logic core_mon_full_perf,
    input wire logic low_side_auto_control,
    input wire logic high_sup_enable,
    input wire logic high_sup_lowpower_enable,
    input wire logic high_sup_full_perf,
    input wire logic high_mon_enable,
    input wire logic high_mon_full_perf,
    input wire logic high_side_auto_control,
    input wire logic low_ctl_write,
    input wire logic deep_sleep_request,
    input wire logic wakeup_event,
    input wire sss_pkg::sss_unit_type core_supervisor,
    input wire sss_pkg::sss_unit_type core_monitor,
    input wire sss_pkg::sss_unit_type supply_supervisor_high,
    input wire sss_pkg::sss_unit_type supply_monitor_high,
    input wire logic low_side_settle_flag,
    input wire logic high_side_settle_flag,
    input wire logic slow_wakeup,
    input wire logic cpu_hold,
    input wire logic in_deep_sleep
);
    timeunit 1ns;
    timeprecision 1ps;
    sss_unit_type x_cs, x_cm, x_hs, x_hm, a_cm;
    logic slow_cfg;
    assign x_cs = dp(core_sup_enable, core_sup_lowpower_enable, core_sup_full_perf,
        low_side_auto_control);
    assign x_cm = dp(core_mon_enable, 1'b1, core_mon_full_perf, low_side_auto_control);
    assign x_hs = dp(high_sup_enable, high_sup_lowpower_enable, high_sup_full_perf,
        high_side_auto_control);
    assign x_hm = dp(high_mon_enable, 1'b1, high_mon_full_perf, high_side_auto_control);
    assign a_cm = ac(core_mon_enable, core_mon_full_perf);
    assign slow_cfg = (core_sup_enable && !core_sup_full_perf) ||
        (core_mon_enable && !core_mon_full_perf);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_enter;
        $rose(in_deep_sleep);
    endsequence
    sequence s_wake;
        in_deep_sleep && wakeup_event;
    endsequence
    a_deep_core_sup: assert property (s_enter |-> core_supervisor == $past(x_cs))
        else $error("core supervisor deep state wrong");
    a_deep_core_mon: assert property (s_enter |-> core_monitor == $past(x_cm))
        else $error("core monitor deep state wrong");
    a_deep_high_sup: assert property (s_enter |-> supply_supervisor_high == $past(x_hs))
        else $error("high supervisor deep state wrong");
    a_deep_high_mon: assert property (s_enter |-> supply_monitor_high == $past(x_hm))
        else $error("high monitor deep state wrong");
    a_wake_speed: assert property (s_enter |-> slow_wakeup == $past(slow_cfg))
        else $error("wakeup speed latched wrong");
    a_wake_restore: assert property (s_wake |=> cpu_hold && !in_deep_sleep &&
        core_monitor == $past(a_cm)) else $error("wakeup restore wrong");
    a_fast_hold_len: assert property ($rose(cpu_hold) && !$past(slow_cfg) |->
        ##200 cpu_hold ##1 !cpu_hold) else $error("fast hold length wrong");
    a_settle_fast: assert property (low_ctl_write && core_sup_full_perf |=>
        low_side_settle_flag [*8] ##193 !low_side_settle_flag) else $error("settle length wrong");
    a_deep_refused: assert property (deep_sleep_request && !in_deep_sleep && !cpu_hold &&
        (low_side_settle_flag || high_side_settle_flag) |=> !in_deep_sleep)
        else $error("deep entry while settling");
endmodule : sss_select_asserts

bind sss_select sss_select_asserts u_chk (.*);

// >>> sim/tb_sss_select.sv
// self-checking bench for the supervisor state selector
module tb_sss_select;
    timeunit 1ns;
    timeprecision 1ps;
    import sss_pkg::*;
    import sss_chk_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic core_sup_enable, core_sup_lowpower_enable, core_sup_full_perf, core_mon_enable;
    logic core_mon_full_perf, low_side_auto_control, high_sup_enable, high_sup_lowpower_enable;
    logic high_sup_full_perf, high_mon_enable, high_mon_full_perf, high_side_auto_control;
    logic low_ctl_write = 1'b0, high_ctl_write = 1'b0, deep_sleep_request = 1'b0;
    logic wakeup_event = 1'b0;
    sss_unit_type core_supervisor, core_monitor, supply_supervisor_high, supply_monitor_high;
    logic low_side_settle_flag, high_side_settle_flag, slow_wakeup, cpu_hold, in_deep_sleep;
    logic [11:0] v = 12'h000;
    logic [11:0] cfgs [7] = '{12'h000, 12'hfff, 12'hfbe, 12'hbae, 12'hc34, 12'hc75, 12'h107};
    int fails = 0;
    int checked = 0;
    assign {core_sup_enable, core_sup_lowpower_enable, core_sup_full_perf, core_mon_enable,
        core_mon_full_perf, low_side_auto_control, high_sup_enable, high_sup_lowpower_enable,
        high_sup_full_perf, high_mon_enable, high_mon_full_perf, high_side_auto_control} = v;
    sss_select DUT (.*);
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask : chk
    task automatic wrap_up;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up
    // bound lies above the longest count, so a stuck level ends the run
    task automatic span(input int s, output int n);
        n = 0;
        while ((s == 0 ? low_side_settle_flag : s == 1 ? high_side_settle_flag : cpu_hold)
            === 1'b1) begin
            n++;
            @(negedge ref_clk);
            deep_sleep_request = 1'b0;
            if (n > 20000) begin
                fails++;
                $display("[ERR] %0t level stuck high", $time);
                wrap_up();
            end
        end
    endtask : span
    task automatic settle(input bit hi, input int exp);
        int n;
        @(negedge ref_clk);
        low_ctl_write = !hi;
        high_ctl_write = hi;
        @(negedge ref_clk);
        low_ctl_write = 1'b0;
        high_ctl_write = 1'b0;
        deep_sleep_request = 1'b1;
        span(hi, n);
        chk(n, exp, "settle length");
        chk(in_deep_sleep, 1'b0, "deep entry while settling");
        $display("settle test done");
    endtask : settle
    task automatic nap(input logic [11:0] c);
        int n;
        logic slow;
        slow = (c[11] && !c[9]) || (c[8] && !c[7]);
        @(negedge ref_clk);
        chk(low_side_settle_flag | high_side_settle_flag, 1'b0, "flags before entry");
        v = c;
        deep_sleep_request = 1'b1;
        @(negedge ref_clk);
        deep_sleep_request = 1'b0;
        chk(in_deep_sleep, 1'b1, "deep entry");
        chk(slow_wakeup, slow, "wakeup speed");
        chk(core_supervisor, dp(c[11], c[10], c[9], c[6]), "core sup deep");
        chk(core_monitor, dp(c[8], 1'b1, c[7], c[6]), "core mon deep");
        chk(supply_supervisor_high, dp(c[5], c[4], c[3], c[0]), "high sup deep");
        chk(supply_monitor_high, dp(c[2], 1'b1, c[1], c[0]), "high mon deep");
        wakeup_event = 1'b1;
        @(negedge ref_clk);
        wakeup_event = 1'b0;
        chk(core_supervisor, ac(c[11], c[9]), "core sup restore");
        chk(supply_monitor_high, ac(c[2], c[1]), "high mon restore");
        chk(core_monitor, ac(c[8], c[7]), "core mon restore");
        chk(supply_supervisor_high, ac(c[5], c[3]), "high sup restore");
        span(2, n);
        chk(n, slow ? 16'd15001 : 16'd201, "hold length");
        // plain 100-cycle (1 us) idle after the hold ends; no main clock halving is modelled
        repeat (100) @(negedge ref_clk);
        $display("sleep test %h done", c);
    endtask : nap
    initial begin
        repeat (5) @(negedge ref_clk);
        rst_n = 1'b1;
        v = 12'h200;
        settle(1'b0, 200);
        v = 12'h000;
        settle(1'b0, 15000);
        v = 12'h008;
        settle(1'b1, 200);
        foreach (cfgs[i]) nap(cfgs[i]);
        @(negedge ref_clk);
        deep_sleep_request = 1'b1;
        @(negedge ref_clk);
        deep_sleep_request = 1'b0;
        rst_n = 1'b0;
        @(negedge ref_clk);
        chk(in_deep_sleep, 1'b0, "deep after reset");
        chk(core_supervisor, sss_off, "unit after reset");
        rst_n = 1'b1;
        $display("reset test done");
        wrap_up();
    end
endmodule : tb_sss_select
